// ==== mcg_params.svh ====
// Constants for the line code generator: register map, fields, resets.
// Assumes inclusion by its bare name from the package and the modules.
`ifndef MCT_PARAMS_SVH
`define MCT_PARAMS_SVH

// Byte addresses of the word-aligned registers
`define MCT_OFF_MAIN    8'h00
`define MCT_OFF_CLOCK   8'h04
`define MCT_OFF_HALF    8'h08
`define MCT_OFF_WORD    8'h0C
`define MCT_OFF_BITOP   8'h10
`define MCT_OFF_LENGTH  8'h14
`define MCT_OFF_STATUS  8'h18

// Main control fields
`define MCT_BIT_RUN     7
`define MCT_BIT_DIR     4
`define MCT_BIT_FMT     1
`define MCT_BIT_IDLE    0
`define MCT_MAIN_MASK   8'h93
`define MCT_MAIN_RST    8'h10

// Other reset values
`define MCT_CLOCK_RST   3'h0
`define MCT_HALF_RST    8'h01
`define MCT_LENGTH_RST  3'h7

// Bit operation register fields
`define MCT_BITOP_VAL   3

// Status fields
`define MCT_ST_BUSY     0
`define MCT_ST_PEND     1
`define MCT_ST_LINE     2

// Delay, in base clocks, of a word written inside the forbidden window; largest clock select
`define MCT_LATE_GAP    2'h2
`define MCT_CKS_MAX     3'h5

`endif

// ==== mcg_pkg.sv ====
// Types shared by the line code generator modules.
// Assumes mcg_params.svh is reachable on the include path.
`include "mcg_params.svh"

package mct_pkg;

  typedef enum logic [2:0] {
    MCT_ST_IDLE = 3'b001,
    MCT_ST_SEND = 3'b010,
    MCT_ST_GAP  = 3'b100
  } mct_state_t;

endpackage

// ==== mcg_tick_if.sv ====
// Carrier between the transmitter and its base clock prescaler.
// Assumes both ends run on clk_sys.
interface mct_tick_if;
  logic [2:0] clock_select;
  logic       run;
  logic       base_tick;

  modport ctrl (output clock_select, output run, input base_tick);
  modport gen  (input clock_select, input run, output base_tick);
endinterface

// ==== mcg_base_clock.sv ====
// Operation base clock prescaler: one-cycle tick at clk_sys / 2^select.
// Assumes a synchronous active-low reset on clk_sys.
`include "mcg_params.svh"

module mct_base_clock
  import mct_pkg::*;
(
  // System
  input  wire logic clk_sys,
  input  wire logic rst_b,
  // Tick carrier
  mct_tick_if.gen   tick
);

  logic [4:0] div_q;
  logic [4:0] div_d;
  logic [4:0] mask;
  logic [2:0] sel;

  always_comb
  begin
    // Codes above the largest divider fall back to it
    sel = (tick.clock_select > `MCT_CKS_MAX) ? `MCT_CKS_MAX : tick.clock_select;
    mask = 5'((6'h01 << sel) - 6'h01);
    div_d = tick.run ? 5'(div_q + 5'h01) : 5'h00;
    tick.base_tick = tick.run && ((div_q & mask) == mask);
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
      div_q <= 5'h00;
    else
      div_q <= div_d;
  end

endmodule // mct_base_clock

// ==== mcg_transmitter.sv ====
// Line code generator: Wishbone classic slave and serial transmitter.
// Assumes a synchronous active-low reset on clk_sys; data in low 8 bits.
//
// Functional notes
// - Main control resets to 10H.
// - Bit7 run, bit4 LSB-first, bit1 plain format.
// - Idle output follows idle-level bit.
// - Byte and single-bit writes to main control.
// - Forbidden window: half bit plus one clock before last bit, and last bit.
// - Late word starts two clocks after last.
// - Three-bit down counter; 000 marks last bit.
// - Bit timing from selected base clock.
`include "mcg_params.svh"

module mct_transmitter
  import mct_pkg::*;
(
  // System
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  // Wishbone classic slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Serial line
  output logic             line_out
);

  mct_tick_if tick ();

  mct_base_clock u_base_clock (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .tick    (tick)
  );

  // Registers
  logic [7:0]  main_q,  main_d;
  logic [2:0]  clock_q, clock_d;
  logic [7:0]  half_q,  half_d;
  logic [2:0]  length_q, length_d;
  logic [7:0]  word_q,  word_d;
  logic        pend_q,  pend_d;
  logic        late_q,  late_d;
  logic        ack_q,   ack_d;
  logic [31:0] rdat_q,  rdat_d;
  // Transmitter
  mct_state_t  state_q, state_d;
  logic [7:0]  shift_q, shift_d;
  logic [2:0]  cnt_q,   cnt_d;
  logic [7:0]  hcnt_q,  hcnt_d;
  logic        phase_q, phase_d;
  logic [1:0]  gap_q,   gap_d;
  logic        line_q,  line_d;

  logic        run;
  logic        wr;
  logic        half_end;
  logic        bit_end;
  logic        forbidden;
  logic        cur_bit;

  function automatic logic pick_bit(input logic [7:0] w, input logic lsb_first);
    return lsb_first ? w[0] : w[7];
  endfunction

  assign run = main_q[`MCT_BIT_RUN];
  assign tick.run = run;
  assign tick.clock_select = clock_q;
  assign wr = wb_cyc_i && wb_stb_i && wb_we_i && ack_q && wb_sel_i[0];
  assign half_end = tick.base_tick && (hcnt_q == 8'(half_q - 8'h01));
  assign bit_end = half_end && phase_q;
  assign cur_bit = pick_bit(shift_q, main_q[`MCT_BIT_DIR]);
  // Half a bit plus one base clock ahead of the last bit, and the last bit
  assign forbidden = (state_q == MCT_ST_SEND) &&
                     ((cnt_q == 3'h0) ||
                      ((cnt_q == 3'h1) && (phase_q ||
                        (hcnt_q == 8'(half_q - 8'h01)))));

  // Register bus
  always_comb
  begin
    main_d   = main_q;
    clock_d  = clock_q;
    half_d   = half_q;
    length_d = length_q;
    word_d   = word_q;
    ack_d    = wb_cyc_i && wb_stb_i && !ack_q;
    rdat_d   = 32'h0000_0000;
    if (wr)
    begin
      unique case (wb_adr_i)
        `MCT_OFF_MAIN:   main_d = wb_dat_i[7:0] & `MCT_MAIN_MASK;
        `MCT_OFF_BITOP:
        begin
          main_d[wb_dat_i[2:0]] = wb_dat_i[`MCT_BITOP_VAL];
          main_d = main_d & `MCT_MAIN_MASK;
        end
        `MCT_OFF_CLOCK:  clock_d = wb_dat_i[2:0];
        // Zero would stall the half-bit counter
        `MCT_OFF_HALF:   half_d = (wb_dat_i[7:0] == 8'h00) ? `MCT_HALF_RST : wb_dat_i[7:0];
        `MCT_OFF_LENGTH: length_d = wb_dat_i[2:0];
        `MCT_OFF_WORD:   word_d = wb_dat_i[7:0];
        default: ;
      endcase
    end
    if (wb_cyc_i && wb_stb_i && !ack_q && !wb_we_i)
    begin
      unique case (wb_adr_i)
        `MCT_OFF_MAIN:   rdat_d = {24'h000000, main_q};
        `MCT_OFF_CLOCK:  rdat_d = {29'h0, clock_q};
        `MCT_OFF_HALF:   rdat_d = {24'h000000, half_q};
        `MCT_OFF_LENGTH: rdat_d = {29'h0, length_q};
        `MCT_OFF_WORD:   rdat_d = {24'h000000, word_q};
        `MCT_OFF_STATUS: rdat_d = {29'h0, line_q, pend_q, state_q != MCT_ST_IDLE};
        default:         rdat_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      main_q   <= `MCT_MAIN_RST;
      clock_q  <= `MCT_CLOCK_RST;
      half_q   <= `MCT_HALF_RST;
      length_q <= `MCT_LENGTH_RST;
      word_q   <= 8'h00;
      ack_q    <= 1'b0;
      rdat_q   <= 32'h0000_0000;
    end
    else
    begin
      main_q   <= main_d;
      clock_q  <= clock_d;
      half_q   <= half_d;
      length_q <= length_d;
      word_q   <= word_d;
      ack_q    <= ack_d;
      rdat_q   <= rdat_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  // Transmitter
  always_comb
  begin
    state_d = state_q;
    shift_d = shift_q;
    cnt_d   = cnt_q;
    hcnt_d  = hcnt_q;
    phase_d = phase_q;
    gap_d   = gap_q;
    pend_d  = pend_q;
    late_d  = late_q;
    unique case (state_q)
      MCT_ST_IDLE:
      begin
        hcnt_d  = 8'h00;
        phase_d = 1'b0;
        if (run && pend_q && tick.base_tick)
        begin
          state_d = MCT_ST_SEND;
          shift_d = word_q;
          cnt_d   = length_q;
          pend_d  = 1'b0;
          late_d  = 1'b0;
        end
      end
      MCT_ST_SEND:
      begin
        if (tick.base_tick)
          hcnt_d = half_end ? 8'h00 : 8'(hcnt_q + 8'h01);
        if (half_end)
          phase_d = !phase_q;
        if (bit_end)
        begin
          shift_d = main_q[`MCT_BIT_DIR] ? {1'b0, shift_q[7:1]} : {shift_q[6:0], 1'b0};
          cnt_d   = 3'(cnt_q - 3'h1);
          if (cnt_q == 3'h0)
          begin
            if (pend_q && late_q)
            begin
              state_d = MCT_ST_GAP;
              gap_d   = 2'h0;
            end
            else if (pend_q)
            begin
              // Continuous transmission with no gap
              shift_d = word_q;
              cnt_d   = length_q;
              pend_d  = 1'b0;
            end
            else
              state_d = MCT_ST_IDLE;
          end
        end
      end
      MCT_ST_GAP:
      begin
        hcnt_d  = 8'h00;
        phase_d = 1'b0;
        if (tick.base_tick)
          gap_d = 2'(gap_q + 2'h1);
        if (tick.base_tick && (2'(gap_q + 2'h1) == `MCT_LATE_GAP))
        begin
          state_d = MCT_ST_SEND;
          shift_d = word_q;
          cnt_d   = length_q;
          pend_d  = 1'b0;
          late_d  = 1'b0;
        end
      end
      default: state_d = MCT_ST_IDLE;
    endcase
    // A new word write wins over the consumption in the same cycle
    if (wr && (wb_adr_i == `MCT_OFF_WORD))
    begin
      pend_d = 1'b1;
      late_d = forbidden;
    end
    if (!run)
    begin
      // Stopping abandons the frame and any waiting word
      state_d = MCT_ST_IDLE;
      pend_d  = 1'b0;
      late_d  = 1'b0;
    end
    if (state_q == MCT_ST_SEND)
      line_d = main_q[`MCT_BIT_FMT] ? cur_bit : (phase_q ? !cur_bit : cur_bit);
    else
      line_d = main_q[`MCT_BIT_IDLE];
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      state_q <= MCT_ST_IDLE;
      shift_q <= 8'h00;
      cnt_q   <= 3'h0;
      hcnt_q  <= 8'h00;
      phase_q <= 1'b0;
      gap_q   <= 2'h0;
      pend_q  <= 1'b0;
      late_q  <= 1'b0;
      line_q  <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      shift_q <= shift_d;
      cnt_q   <= cnt_d;
      hcnt_q  <= hcnt_d;
      phase_q <= phase_d;
      gap_q   <= gap_d;
      pend_q  <= pend_d;
      late_q  <= late_d;
      line_q  <= line_d;
    end
  end

  assign line_out = line_q;

endmodule // mct_transmitter

// ==== mcg_monitor.sv ====
// Checker for the line code generator bus and serial line.
// Assumes binding onto mct_transmitter, one clk_sys domain.
module mct_monitor (
  // System
  input wire logic        clk_sys,
  input wire logic        rst_b,
  // Bus
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // Line
  input wire logic        line_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  wire logic rd_ack = wb_ack_o && !wb_we_i;
  property p_rst; $rose(rst_b) |-> !line_out; endproperty
  a_rst: assert property (p_rst) else $error("line high after reset");
  property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("no ack");
  property p_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_pulse: assert property (p_pulse) else $error("ack too long");
  property p_cause; wb_ack_o |-> $past(wb_cyc_i && wb_stb_i); endproperty
  a_cause: assert property (p_cause) else $error("ack unasked");
  property p_main; rd_ack && wb_adr_i == 8'h00 |-> (wb_dat_o & 32'hFFFFFF6C) == 32'h0;
  endproperty
  a_main: assert property (p_main) else $error("main reserved set");
  // Stopped main control read must match the idle line level
  property p_idle; rd_ack && wb_adr_i == 8'h00 && !wb_dat_o[7] |-> line_out == wb_dat_o[0];
  endproperty
  a_idle: assert property (p_idle) else $error("idle level wrong");
  property p_cks; rd_ack && wb_adr_i == 8'h04 |-> wb_dat_o[31:3] == 29'h0; endproperty
  a_cks: assert property (p_cks) else $error("select too wide");
  property p_len; rd_ack && wb_adr_i == 8'h14 |-> wb_dat_o[31:3] == 29'h0; endproperty
  a_len: assert property (p_len) else $error("length too wide");
  c_rd: cover property (rd_ack && wb_adr_i == 8'h00);
  c_wr: cover property (wb_ack_o && wb_we_i && wb_adr_i == 8'h0C);
  c_rise: cover property ($rose(line_out));
endmodule // mct_monitor

bind mct_transmitter mct_monitor u_mon (
  .clk_sys  (clk_sys),
  .rst_b    (rst_b),
  .wb_cyc_i (wb_cyc_i),
  .wb_stb_i (wb_stb_i),
  .wb_we_i  (wb_we_i),
  .wb_adr_i (wb_adr_i),
  .wb_dat_o (wb_dat_o),
  .wb_ack_o (wb_ack_o),
  .line_out (line_out)
);

// ==== mcg_line_rx.sv ====
// Receiver model: samples the line from its first rise.
// Assumes idle low; the bench sets spacing and sample count.
module mct_line_rx (
  // System
  input  wire logic        clk_sys,
  // Line and setup
  input  wire logic        line_out,
  input  wire logic [7:0]  spacing,
  input  wire logic [5:0]  count,
  // Result
  output logic      [31:0] halves,
  output int               frames
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    frames = 0;
    halves = 32'h0;
    forever
    begin
      // Count of zero keeps it deaf while idle is high
      @(posedge clk_sys iff (line_out === 1'b1 && count != 6'h0));
      halves = 32'h0;
      for (int i = 1; i <= count; i++)
      begin
        halves = {halves[30:0], line_out};
        if (i < count)
          repeat (spacing) @(posedge clk_sys);
      end
      frames++;
    end
  end
endmodule // mct_line_rx

// ==== mcg_transmitter_test.sv ====
// Self-checking bench for the line code generator over Wishbone.
// Assumes mct_line_rx and the bound checker are compiled first.
module mct_transmitter_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_sys, rst_b, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, line_out;
  logic [3:0]  wb_sel_i;
  logic [7:0]  wb_adr_i, spacing;
  logic [5:0]  count;
  logic [31:0] wb_dat_i, wb_dat_o, halves, q;
  int          fails, cmp_count, frames;

  mct_transmitter dut (
    .clk_sys  (clk_sys),
    .rst_b    (rst_b),
    .wb_cyc_i (wb_cyc_i),
    .wb_stb_i (wb_stb_i),
    .wb_we_i  (wb_we_i),
    .wb_adr_i (wb_adr_i),
    .wb_sel_i (wb_sel_i),
    .wb_dat_i (wb_dat_i),
    .wb_dat_o (wb_dat_o),
    .wb_ack_o (wb_ack_o),
    .line_out (line_out)
  );
  mct_line_rx rx (
    .clk_sys  (clk_sys),
    .line_out (line_out),
    .spacing  (spacing),
    .count    (count),
    .halves   (halves),
    .frames   (frames)
  );

  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic check(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e)
    begin
      fails++;
      $display("[FAIL] t=%0t seen %h exp %h", $time, s, e);
    end
  endtask

  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    @(posedge clk_sys);
    while (wb_ack_o !== 1'b1) @(posedge clk_sys);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(a, 1'b0, 32'h0);
    check(q, e);
  endtask

  // Second word d cycles after the frame rises, when d is not zero
  task automatic send(input logic [7:0] m, k, h, l, w, s, input logic [5:0] c,
                      input int d, input logic [31:0] e);
    int f;
    bus(8'h00, 1'b1, 32'h0);
    bus(8'h04, 1'b1, {24'h0, k});
    bus(8'h08, 1'b1, {24'h0, h});
    bus(8'h14, 1'b1, {24'h0, l});
    spacing <= s;
    count <= c;
    f = frames;
    bus(8'h00, 1'b1, {24'h0, m});
    bus(8'h0C, 1'b1, {24'h0, w});
    if (d > 0)
    begin
      @(posedge clk_sys iff line_out === 1'b1);
      repeat (d) @(posedge clk_sys);
      bus(8'h0C, 1'b1, {24'h0, w});
    end
    while (frames == f) @(posedge clk_sys);
    check(halves, e);
    $display("frame test done");
  endtask

  task end_of_test;
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial
  begin
    #50000;
    fails++;
    end_of_test();
  end

  initial
  begin
    rst_b = 1'b0;
    {wb_cyc_i, wb_stb_i, wb_we_i} = 3'h0;
    wb_sel_i = 4'hF;
    wb_adr_i = 8'h00;
    wb_dat_i = 32'h0;
    spacing = 8'h01;
    count = 6'h00;
    fails = 0;
    cmp_count = 0;
    repeat (3) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    rd(8'h00, 32'h10);
    rd(8'h04, 32'h0);
    rd(8'h14, 32'h7);
    rd(8'h1C, 32'h0);
    check({31'h0, line_out}, 32'h0);
    bus(8'h10, 1'b1, 32'h9);
    bus(8'h10, 1'b1, 32'h8);
    rd(8'h00, 32'h13);
    check({31'h0, line_out}, 32'h1);
    rd(8'h18, 32'h4);
    bus(8'h00, 1'b1, 32'h0);
    rd(8'h00, 32'h0);
    check({31'h0, line_out}, 32'h0);
    $display("register test done");
    send(8'h80, 8'h0, 8'h1, 8'h7, 8'hA5, 8'h1, 6'h10, 0, 32'h9966);
    send(8'h92, 8'h1, 8'h2, 8'h7, 8'h35, 8'h4, 6'h10, 0, 32'hCCF0);
    send(8'h80, 8'h0, 8'h2, 8'h3, 8'h99, 8'h2, 6'h10, 1, 32'h9696);
    send(8'h80, 8'h0, 8'h2, 8'h3, 8'h99, 8'h2, 6'h11, 10, 32'h12C96);
    end_of_test();
  end
endmodule // mct_transmitter_test
